// ===== hdl/sad_decoder.sv
// Purpose: System address decoder steering cycles to DRAM, south link or
//          the PCI Express port, with a register port for its windows.
// Assumes: Request inputs are synchronous to core_clk_in and stable while
//          req_valid_in is high.
// Notes:   The target is chosen combinationally in the request cycle.
//          Overlapping windows are not detected; a fixed branch order
//          picks one, so software must keep windows apart.
//          Write-back cycles to the south link are not handled.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module sad_decoder
	import sad_pkg::*;
#(
	parameter int DRAM_AW = 33
) (
	// Clock and reset.
	input  wire logic                core_clk_in,
	input  wire logic                rst_n_in,
	// Register port.
	input  wire logic [7:0]          reg_addr_in,
	input  wire logic [31:0]         reg_wdata_in,
	input  wire logic                reg_wr_in,
	input  wire logic                reg_rd_in,
	output logic      [31:0]         reg_rdata_out,
	// Request to decode.
	input  wire logic                req_valid_in,
	input  wire logic [63:0]         req_addr_in,
	input  wire logic [1:0]          req_src_in,
	input  wire logic                req_write_in,
	input  wire logic                req_io_in,
	input  wire logic                req_nosnoop_in,
	// Decode result.
	output logic                     tgt_dram_out,
	output logic                     tgt_south_out,
	output logic                     tgt_pcie_out,
	output logic                     tgt_regs_out,
	output logic                     tgt_invalid_out,
	output logic      [DRAM_AW-1:0]  dram_addr_out
);

	// Configuration state.
	logic [31:0] ctrl_r;
	logic [11:0] low_dram_top_r;
	logic [23:0] egress_reg_window_base_r;
	logic [21:0] internal_reg_window_base_r;
	logic [9:0]  flat_config_window_base_r;
	logic [23:0] south_link_reg_window_base_r;
	logic [11:0] np_base_r;
	logic [11:0] np_limit_r;
	logic [11:0] pf_base_r;
	logic [11:0] pf_limit_r;
	logic [31:0] upf_base_r;
	logic [31:0] upf_limit_r;
	logic [3:0]  io_base_r;
	logic [3:0]  io_limit_r;
	logic [15:0] rcl_base_r;
	logic [15:0] rcl_limit_r;
	logic [15:0] upper_top_r;
	logic [25:0] attr_r;
	logic [2:0]  last_tgt_r;
	logic [15:0] req_count_r;

	// Decode working signals.
	sad_src_t    src;
	sad_tgt_t    tgt;
	logic [63:0] a;
	logic [63:0] low_top;
	logic [63:0] phys;
	logic        is_upstream;
	logic        np_hit;
	logic        pf_hit;
	logic        pcie_mem_hit;
	logic        dev0_hit;
	logic        rcl_hit;
	logic [3:0]  seg;
	logic        seg_re;
	logic        seg_we;

	// Inclusive range check on 1 MB granules; an empty window never hits.
	// A base above its limit is how an unused window is switched off.
	function automatic logic in_range(input logic [43:0] v,
		input logic [43:0] lo, input logic [43:0] hi);
		in_range = (lo <= hi) && (v >= lo) && (v <= hi);
	endfunction

	// Shadow segment index: 0..7 expansion, 8..11 extended BIOS, 12 BIOS.
	function automatic logic [3:0] seg_of(input logic [19:0] v);
		if (v[19:16] == 4'hF) begin
			seg_of = 4'd12;
		end else begin
			seg_of = 4'(v[17:14]);
		end
	endfunction

	// Request fields in decode form; source code 3 counts as upstream.
	assign src     = sad_src_t'(req_src_in);
	assign a       = req_addr_in;
	assign low_top = {32'h0, low_dram_top_r, 20'h0_0000};
	assign is_upstream = (src != SAD_SRC_HOST);

	// PCI Express memory windows; only the prefetchable one takes upper bits from the upper pair.
	assign np_hit = (a[63:32] == 32'h0) &&
		in_range({12'h0, a[63:32]} << 12 | {32'h0, a[31:20]},
		{32'h0, np_base_r}, {32'h0, np_limit_r});
	assign pf_hit = in_range(a[63:20], {upf_base_r, pf_base_r},
		{upf_limit_r, pf_limit_r});
	assign pcie_mem_hit = np_hit || pf_hit;

	// Reclaim window above 4 GB.
	assign rcl_hit = ctrl_r[SAD_CTRL_RECLAIM_EN] && (a >= SAD_FOUR_GB) &&
		in_range(a[63:20], {28'h0, rcl_base_r}, {28'h0, rcl_limit_r});

	// Segment attribute lookup.
	// Bit 0 of each pair enables reads, bit 1 enables writes.
	assign seg    = seg_of(a[19:0]);
	assign seg_re = attr_r[{seg, 1'b0}];
	assign seg_we = attr_r[{seg, 1'b1}];

	// Device-0 register windows of fixed sizes, save the flat window whose size control bits 3 and 4 pick.
	// A bit set above bit 35 keeps all device-0 windows from matching.
	always_comb begin
		logic flat_hit;
		flat_hit = 1'b0;
		unique case (ctrl_r[SAD_CTRL_FLAT_SIZE +: 2])
			SAD_FLAT_128M: flat_hit = (a[35:27] ==
				flat_config_window_base_r[9:1]);
			SAD_FLAT_64M: flat_hit = (a[35:26] ==
				flat_config_window_base_r);
			default: flat_hit = (a[35:28] ==
				flat_config_window_base_r[9:2]);
		endcase
		dev0_hit = (a[63:36] == 28'h0) && (
			(ctrl_r[SAD_CTRL_EGRESS_EN] &&
			 a[35:12] == egress_reg_window_base_r) ||
			(ctrl_r[SAD_CTRL_INTERNAL_EN] &&
			 a[35:14] == internal_reg_window_base_r) ||
			(ctrl_r[SAD_CTRL_SOUTH_EN] &&
			 a[35:12] == south_link_reg_window_base_r) ||
			(ctrl_r[SAD_CTRL_FLAT_EN] && flat_hit));
	end

	// Main target selection, memory regions taking priority over windows save south link writes below low DRAM top.
	// After the I/O check, addresses above 36 bits are tested, then regions from the lowest address up, so one branch hits.
	always_comb begin
		tgt  = SAD_TGT_NONE;
		phys = a;
		if (!req_valid_in) begin
			tgt = SAD_TGT_NONE;
		end else if (req_io_in) begin
			// I/O space is its own map of 64 KB plus three bytes.
			if (a[63:17] != 47'h0 || a[16:0] > SAD_IO_LAST) begin
				tgt = SAD_TGT_INVALID;
			end else if (!a[16] && io_base_r <= io_limit_r &&
				a[15:12] >= io_base_r && a[15:12] <= io_limit_r) begin
				tgt = SAD_TGT_PCIE;
			end else begin
				tgt = SAD_TGT_SOUTH;
			end
		end else if (a[63:SAD_HOST_AW] != 28'h0) begin
			// Beyond the 36-bit host space the upper window claims; otherwise host cycles go south and upstream ones are invalid.
			if (pf_hit) begin
				tgt = SAD_TGT_PCIE;
			end else if (is_upstream) begin
				tgt = SAD_TGT_INVALID;
			end else begin
				tgt = SAD_TGT_SOUTH;
			end
		end else if (a < SAD_DOS_TOP) begin
			tgt = SAD_TGT_DRAM;
		end else if (a < SAD_SHADOW_BOT) begin
			// Legacy video buffer lives on the south link.
			tgt = SAD_TGT_SOUTH;
		end else if (a < SAD_LEGACY_TOP) begin
			// Non-snooped upstream cycles bypass the attributes entirely.
			if (is_upstream && req_nosnoop_in) begin
				tgt = SAD_TGT_DRAM;
			end else if (req_write_in ? seg_we : seg_re) begin
				tgt = SAD_TGT_DRAM;
			end else begin
				// No alternate DRAM address is ever formed here.
				tgt = SAD_TGT_SOUTH;
			end
		end else if (a < low_top) begin
			// Memory wins over overlapping windows, except south link writes.
			if (src == SAD_SRC_SOUTH && req_write_in && pcie_mem_hit) begin
				tgt = SAD_TGT_PCIE;
			end else begin
				tgt = SAD_TGT_DRAM;
			end
		end else if (a < SAD_FOUR_GB) begin
			// Nothing here is moved above low DRAM top; fixed order wins.
			if (dev0_hit) begin
				tgt = SAD_TGT_REGS;
			end else if (pcie_mem_hit) begin
				tgt = SAD_TGT_PCIE;
			end else begin
				tgt = SAD_TGT_SOUTH;
			end
		end else if (rcl_hit) begin
			phys = a - {28'h0, rcl_base_r, 20'h0_0000} + low_top;
			tgt  = SAD_TGT_DRAM;
		end else if (a < {28'h0, upper_top_r, 20'h0_0000}) begin
			tgt = SAD_TGT_DRAM;
		end else if (dev0_hit) begin
			tgt = SAD_TGT_REGS;
		end else if (pcie_mem_hit) begin
			tgt = SAD_TGT_PCIE;
		end else begin
			tgt = SAD_TGT_SOUTH;
		end
		// DRAM ends at 8 GB whatever the windows say.
		// This also catches a reclaim result pushed past the DRAM end.
		if (tgt == SAD_TGT_DRAM && phys >= SAD_DRAM_MAX) begin
			tgt = SAD_TGT_INVALID;
		end
	end

	// One-hot target outputs and the DRAM address, valid this cycle.
	// The DRAM address is forced to zero whenever DRAM is not the target.
	assign tgt_dram_out    = (tgt == SAD_TGT_DRAM);
	assign tgt_south_out   = (tgt == SAD_TGT_SOUTH);
	assign tgt_pcie_out    = (tgt == SAD_TGT_PCIE);
	assign tgt_regs_out    = (tgt == SAD_TGT_REGS);
	assign tgt_invalid_out = (tgt == SAD_TGT_INVALID);
	assign dram_addr_out   = tgt_dram_out ? phys[DRAM_AW-1:0] :
		{DRAM_AW{1'b0}};

	// Window and control registers written by software.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_r                       <= SAD_RST_CTRL;
			low_dram_top_r               <= SAD_RST_LOW_TOP;
			egress_reg_window_base_r     <= 24'h00_0000;
			internal_reg_window_base_r   <= 22'h00_0000;
			flat_config_window_base_r    <= 10'h000;
			south_link_reg_window_base_r <= 24'h00_0000;
			np_base_r                    <= 12'hFFF;
			np_limit_r                   <= 12'h000;
			pf_base_r                    <= 12'hFFF;
			pf_limit_r                   <= 12'h000;
			upf_base_r                   <= 32'h0000_0000;
			upf_limit_r                  <= 32'h0000_0000;
			io_base_r                    <= 4'hF;
			io_limit_r                   <= 4'h0;
			rcl_base_r                   <= 16'hFFFF;
			rcl_limit_r                  <= 16'h0000;
			upper_top_r                  <= 16'h0000;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				SAD_OFS_CTRL:      ctrl_r <= {25'h0, reg_wdata_in[6:0]};
				SAD_OFS_LOW_TOP:   low_dram_top_r <= reg_wdata_in[31:20];
				SAD_OFS_EGRESS:
					egress_reg_window_base_r <= reg_wdata_in[23:0];
				SAD_OFS_INTERNAL:
					internal_reg_window_base_r <= reg_wdata_in[21:0];
				SAD_OFS_FLAT:
					flat_config_window_base_r <= reg_wdata_in[9:0];
				SAD_OFS_SOUTH_REG:
					south_link_reg_window_base_r <= reg_wdata_in[23:0];
				SAD_OFS_NP_WIN: begin
					np_base_r  <= reg_wdata_in[11:0];
					np_limit_r <= reg_wdata_in[27:16];
				end
				SAD_OFS_PF_WIN: begin
					pf_base_r  <= reg_wdata_in[11:0];
					pf_limit_r <= reg_wdata_in[27:16];
				end
				SAD_OFS_UPF_BASE:  upf_base_r <= reg_wdata_in;
				SAD_OFS_UPF_LIMIT: upf_limit_r <= reg_wdata_in;
				SAD_OFS_IO_WIN: begin
					io_base_r  <= reg_wdata_in[3:0];
					io_limit_r <= reg_wdata_in[11:8];
				end
				SAD_OFS_RCL_BASE:  rcl_base_r <= reg_wdata_in[15:0];
				SAD_OFS_RCL_LIMIT: rcl_limit_r <= reg_wdata_in[15:0];
				SAD_OFS_UPPER_TOP: upper_top_r <= reg_wdata_in[15:0];
				default: ;
			endcase
		end
	end

	// Shadow attributes: two bits per segment, read enable low.
	// Segment 12 alone spans the whole 64 KB area below 1 MB.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			attr_r <= SAD_RST_ATTR;
		end else if (reg_wr_in && reg_addr_in == SAD_OFS_ATTR_LO) begin
			attr_r[15:0] <= reg_wdata_in[15:0];
		end else if (reg_wr_in && reg_addr_in == SAD_OFS_ATTR_HI) begin
			attr_r[25:16] <= reg_wdata_in[9:0];
		end
	end

	// Status: last decoded target and a count of decoded requests.
	// The count wraps silently; it is a debug aid and steers nothing.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_tgt_r  <= 3'h0;
			req_count_r <= 16'h0000;
		end else if (req_valid_in) begin
			last_tgt_r  <= 3'(tgt);
			req_count_r <= req_count_r + 16'h0001;
		end
	end

	// Read data stands in the cycle after the read strobe only.
	// Unmapped offsets and idle cycles read as zero.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			unique case (reg_addr_in)
				SAD_OFS_CTRL:      reg_rdata_out <= ctrl_r;
				SAD_OFS_LOW_TOP:
					reg_rdata_out <= {low_dram_top_r, 20'h0_0000};
				SAD_OFS_EGRESS:
					reg_rdata_out <= {8'h00, egress_reg_window_base_r};
				SAD_OFS_INTERNAL:
					reg_rdata_out <= {10'h000, internal_reg_window_base_r};
				SAD_OFS_FLAT:
					reg_rdata_out <= {22'h00_0000, flat_config_window_base_r};
				SAD_OFS_SOUTH_REG:
					reg_rdata_out <= {8'h00, south_link_reg_window_base_r};
				SAD_OFS_NP_WIN:
					reg_rdata_out <= {4'h0, np_limit_r, 4'h0, np_base_r};
				SAD_OFS_PF_WIN:
					reg_rdata_out <= {4'h0, pf_limit_r, 4'h0, pf_base_r};
				SAD_OFS_UPF_BASE:  reg_rdata_out <= upf_base_r;
				SAD_OFS_UPF_LIMIT: reg_rdata_out <= upf_limit_r;
				SAD_OFS_IO_WIN:
					reg_rdata_out <= {20'h0_0000, io_limit_r, 4'h0, io_base_r};
				SAD_OFS_RCL_BASE:  reg_rdata_out <= {16'h0000, rcl_base_r};
				SAD_OFS_RCL_LIMIT: reg_rdata_out <= {16'h0000, rcl_limit_r};
				SAD_OFS_UPPER_TOP: reg_rdata_out <= {16'h0000, upper_top_r};
				SAD_OFS_ATTR_LO:   reg_rdata_out <= {16'h0000, attr_r[15:0]};
				SAD_OFS_ATTR_HI:
					reg_rdata_out <= {22'h00_0000, attr_r[25:16]};
				SAD_OFS_STATUS:
					reg_rdata_out <= {req_count_r, 13'h0000, last_tgt_r};
				default:           reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ===== include/sad_pkg.sv
// Purpose: Constants and types shared by the system address decoder.
// Assumes: 32-bit register port with byte offsets that are multiples of four.
// Notes:   Addresses are carried at 64 bits so upper windows can be compared.
package sad_pkg;

	// Register byte offsets.
	localparam logic [7:0] SAD_OFS_CTRL      = 8'h00;
	localparam logic [7:0] SAD_OFS_LOW_TOP   = 8'h04;
	localparam logic [7:0] SAD_OFS_EGRESS    = 8'h08;
	localparam logic [7:0] SAD_OFS_INTERNAL  = 8'h0C;
	localparam logic [7:0] SAD_OFS_FLAT      = 8'h10;
	localparam logic [7:0] SAD_OFS_SOUTH_REG = 8'h14;
	localparam logic [7:0] SAD_OFS_NP_WIN    = 8'h18;
	localparam logic [7:0] SAD_OFS_PF_WIN    = 8'h1C;
	localparam logic [7:0] SAD_OFS_UPF_BASE  = 8'h20;
	localparam logic [7:0] SAD_OFS_UPF_LIMIT = 8'h24;
	localparam logic [7:0] SAD_OFS_IO_WIN    = 8'h28;
	localparam logic [7:0] SAD_OFS_RCL_BASE  = 8'h2C;
	localparam logic [7:0] SAD_OFS_RCL_LIMIT = 8'h30;
	localparam logic [7:0] SAD_OFS_UPPER_TOP = 8'h34;
	localparam logic [7:0] SAD_OFS_ATTR_LO   = 8'h38;
	localparam logic [7:0] SAD_OFS_ATTR_HI   = 8'h3C;
	localparam logic [7:0] SAD_OFS_STATUS    = 8'h40;

	// Control register bit positions.
	localparam int SAD_CTRL_EGRESS_EN   = 0;
	localparam int SAD_CTRL_INTERNAL_EN = 1;
	localparam int SAD_CTRL_FLAT_EN     = 2;
	localparam int SAD_CTRL_FLAT_SIZE   = 3;
	localparam int SAD_CTRL_SOUTH_EN    = 5;
	localparam int SAD_CTRL_RECLAIM_EN  = 6;

	// Reset values; every attribute segment starts disabled.
	localparam logic [31:0] SAD_RST_CTRL    = 32'h0000_0000;
	localparam logic [11:0] SAD_RST_LOW_TOP = 12'h001;
	localparam logic [25:0] SAD_RST_ATTR    = 26'h000_0000;

	// Fixed map boundaries.
	localparam logic [63:0] SAD_DOS_TOP    = 64'h0000_0000_000A_0000;
	localparam logic [63:0] SAD_SHADOW_BOT = 64'h0000_0000_000C_0000;
	localparam logic [63:0] SAD_LEGACY_TOP = 64'h0000_0000_0010_0000;
	localparam logic [63:0] SAD_FOUR_GB    = 64'h0000_0001_0000_0000;
	localparam logic [63:0] SAD_DRAM_MAX   = 64'h0000_0002_0000_0000;
	localparam logic [16:0] SAD_IO_LAST    = 17'h1_0002;
	localparam int          SAD_HOST_AW    = 36;
	localparam int          SAD_SEG_COUNT  = 13;

	// Flat configuration window sizes.
	localparam logic [1:0] SAD_FLAT_256M = 2'h0;
	localparam logic [1:0] SAD_FLAT_128M = 2'h1;
	localparam logic [1:0] SAD_FLAT_64M  = 2'h2;

	// Request sources and decode targets.
	typedef enum logic [1:0] {SAD_SRC_HOST, SAD_SRC_PCIE, SAD_SRC_SOUTH}
		sad_src_t;
	typedef enum logic [2:0] {SAD_TGT_NONE, SAD_TGT_DRAM, SAD_TGT_SOUTH,
		SAD_TGT_PCIE, SAD_TGT_REGS, SAD_TGT_INVALID} sad_tgt_t;

endpackage

// ===== tb/sad_decoder_chk_sva.sv
// Purpose: Port assertions for the system address decoder.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every decoder instance.
`timescale 1ns/1ns
module sad_decoder_chk
	import sad_pkg::*;
#(
	parameter int DRAM_AW = 33
) (
	// Clock and reset.
	input wire logic               core_clk_in,
	input wire logic               rst_n_in,
	// Request.
	input wire logic               req_valid_in,
	input wire logic [63:0]        req_addr_in,
	input wire logic [1:0]         req_src_in,
	input wire logic               req_write_in,
	input wire logic               req_io_in,
	input wire logic               req_nosnoop_in,
	input wire logic               reg_wr_in,
	// Decode result.
	input wire logic               tgt_dram_out,
	input wire logic               tgt_south_out,
	input wire logic               tgt_pcie_out,
	input wire logic               tgt_regs_out,
	input wire logic               tgt_invalid_out,
	input wire logic [DRAM_AW-1:0] dram_addr_out
);
	logic       mem_v;
	logic       shd;
	logic       same_a;
	logic [4:0] tgts;

	// Qualifiers shared by several properties.
	assign mem_v  = req_valid_in && !req_io_in;
	assign shd    = req_addr_in >= SAD_SHADOW_BOT &&
		req_addr_in < SAD_LEGACY_TOP;
	assign same_a = dram_addr_out == req_addr_in[DRAM_AW-1:0];
	assign tgts   = {tgt_dram_out, tgt_south_out, tgt_pcie_out,
		tgt_regs_out, tgt_invalid_out};

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_one_hot;
		req_valid_in |-> $onehot(tgts);
	endproperty
	a_one_hot: assert property (p_one_hot)
		else $error("decoder claim is not one-hot");
	property p_idle;
		!req_valid_in |-> tgts == 5'h0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("decoder claims while idle");
	property p_hold;
		req_valid_in && $past(req_valid_in) && !$past(reg_wr_in) &&
		$stable(req_addr_in) && $stable(req_src_in) &&
		$stable({req_write_in, req_io_in, req_nosnoop_in}) |->
		$stable(tgts) && $stable(dram_addr_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("decode changed with steady inputs");
	property p_dos;
		mem_v && req_addr_in < SAD_DOS_TOP |-> tgt_dram_out && same_a;
	endproperty
	a_dos: assert property (p_dos)
		else $error("low area not sent to dram unchanged");
	property p_io_top;
		req_valid_in && req_io_in && req_addr_in[16:0] > SAD_IO_LAST
		|-> tgt_invalid_out;
	endproperty
	a_io_top: assert property (p_io_top)
		else $error("io cycle beyond io space not invalid");
	property p_io_mem;
		req_valid_in && req_io_in |-> !tgt_dram_out;
	endproperty
	a_io_mem: assert property (p_io_mem)
		else $error("io cycle reached dram");
	property p_up36;
		mem_v && req_src_in != 2'(SAD_SRC_HOST) &&
		req_addr_in[63:36] != 28'h000_0000 |->
		tgt_pcie_out || tgt_invalid_out;
	endproperty
	a_up36: assert property (p_up36)
		else $error("upstream cycle above 36 bits misrouted");
	property p_nosnoop;
		mem_v && shd && req_nosnoop_in &&
		req_src_in != 2'(SAD_SRC_HOST) |-> tgt_dram_out && same_a;
	endproperty
	a_nosnoop: assert property (p_nosnoop)
		else $error("non-snooped shadow cycle not sent to dram");
	property p_shadow;
		mem_v && shd |-> (tgt_dram_out && same_a) || tgt_south_out;
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("shadow cycle sent elsewhere or remapped");
endmodule

bind sad_decoder sad_decoder_chk #(.DRAM_AW(DRAM_AW)) i_sad_decoder_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.req_valid_in(req_valid_in), .req_addr_in(req_addr_in),
	.req_src_in(req_src_in), .req_write_in(req_write_in),
	.req_io_in(req_io_in), .req_nosnoop_in(req_nosnoop_in),
	.reg_wr_in(reg_wr_in), .tgt_dram_out(tgt_dram_out),
	.tgt_south_out(tgt_south_out), .tgt_pcie_out(tgt_pcie_out),
	.tgt_regs_out(tgt_regs_out), .tgt_invalid_out(tgt_invalid_out),
	.dram_addr_out(dram_addr_out));

// ===== tb/sad_far_model.sv
// Purpose: Far-side targets that report which of them claimed a cycle.
// Assumes: Claim lines come straight from the decoder.
// Notes:   A double claim reads as no claim, which no test expects.
`timescale 1ns/1ns
module sad_far_model
	import sad_pkg::*;
(
	// Claim lines.
	input  wire logic       dram_in,
	input  wire logic       south_in,
	input  wire logic       pcie_in,
	input  wire logic       regs_in,
	input  wire logic       invalid_in,
	// Code of the claiming target.
	output logic      [2:0] route_code_out
);
	// Requesters here never issue write-back cycles, so the south link
	// only sees uncacheable traffic.
	always_comb begin
		case ({dram_in, south_in, pcie_in, regs_in, invalid_in})
			5'b10000: route_code_out = SAD_TGT_DRAM;
			5'b01000: route_code_out = SAD_TGT_SOUTH;
			5'b00100: route_code_out = SAD_TGT_PCIE;
			5'b00010: route_code_out = SAD_TGT_REGS;
			5'b00001: route_code_out = SAD_TGT_INVALID;
			default:  route_code_out = SAD_TGT_NONE;
		endcase
	end
endmodule

// ===== tb/test_sad_decoder.sv
// Purpose: Self-checking bench for the system address decoder.
// Assumes: Windows are programmed apart from each other.
// Notes:   Table rows run on reset settings; windows are tested after.
`timescale 1ns/1ns
module test_sad_decoder
	import sad_pkg::*;
;
	typedef struct {
		logic [39:0] a;
		logic [1:0]  s;
		logic [2:0]  f;
		sad_tgt_t    t;
		logic [32:0] d;
	} sad_row_t;
	logic        core_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic [31:0] reg_rdata_out;
	logic        req_valid_in = 1'b0;
	logic [63:0] req_addr_in = 64'h0;
	logic [1:0]  req_src_in = 2'h0;
	logic [2:0]  req_flags = 3'h0;
	wire  [4:0]  tgts;
	logic [32:0] dram_addr_out;
	logic [2:0]  route_code;
	int          err_count = 0;
	int          cmp_count = 0;
	// Flags are write, io, non-snooped; sources 0 host, 1 pcie, 2 south.
	sad_row_t    rows [14] = '{
		'{40'h00_0000_1000, 2'h0, 3'b000, SAD_TGT_DRAM, 33'h0_0000_1000},
		'{40'h00_0009_FFFF, 2'h0, 3'b100, SAD_TGT_DRAM, 33'h0_0009_FFFF},
		'{40'h00_000A_0000, 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0},
		'{40'h00_000C_0000, 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0},
		'{40'h00_000F_0000, 2'h0, 3'b100, SAD_TGT_SOUTH, 33'h0},
		'{40'h00_000E_4000, 2'h1, 3'b001, SAD_TGT_DRAM, 33'h0_000E_4000},
		'{40'h00_000D_C000, 2'h2, 3'b101, SAD_TGT_DRAM, 33'h0_000D_C000},
		'{40'h00_000F_8000, 2'h0, 3'b001, SAD_TGT_SOUTH, 33'h0},
		'{40'h02_0000_0000, 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0},
		'{40'h10_0000_0000, 2'h1, 3'b000, SAD_TGT_INVALID, 33'h0},
		'{40'h10_0000_0000, 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0},
		'{40'h00_0001_0002, 2'h0, 3'b010, SAD_TGT_SOUTH, 33'h0},
		'{40'h00_0001_0003, 2'h0, 3'b010, SAD_TGT_INVALID, 33'h0},
		'{40'h00_0020_0000, 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0}};
	logic [7:0]  wofs [3] = '{SAD_OFS_INTERNAL, SAD_OFS_EGRESS,
		SAD_OFS_SOUTH_REG};
	logic [31:0] wfld [3] = '{32'h0003_FB44, 32'h000F_ED18, 32'h000F_ED19};
	logic [31:0] wbas [3] = '{32'hFED1_0000, 32'hFED1_8000, 32'hFED1_9000};
	logic [31:0] wsiz [3] = '{32'h0000_4000, 32'h0000_1000, 32'h0000_1000};
	int          wbit [3] = '{SAD_CTRL_INTERNAL_EN, SAD_CTRL_EGRESS_EN,
		SAD_CTRL_SOUTH_EN};

	// Clock at 100 MHz.
	always #5 core_clk_in = ~core_clk_in;

	sad_decoder i_sad_decoder (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .req_valid_in(req_valid_in),
		.req_addr_in(req_addr_in), .req_src_in(req_src_in),
		.req_write_in(req_flags[2]), .req_io_in(req_flags[1]),
		.req_nosnoop_in(req_flags[0]), .tgt_dram_out(tgts[4]),
		.tgt_south_out(tgts[3]), .tgt_pcie_out(tgts[2]),
		.tgt_regs_out(tgts[1]), .tgt_invalid_out(tgts[0]),
		.dram_addr_out(dram_addr_out));
	sad_far_model i_sad_far_model (
		.dram_in(tgts[4]), .south_in(tgts[3]), .pcie_in(tgts[2]),
		.regs_in(tgts[1]), .invalid_in(tgts[0]),
		.route_code_out(route_code));

	// Compares one value and counts the outcome.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Prints the verdict and stops.
	task automatic tally_and_finish();
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// One-cycle register read; data is checked in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge core_clk_in);
		chk(64'(reg_rdata_out), 64'(exp));
	endtask
	// Presents a request and checks target and dram address that cycle.
	task automatic route(input logic [63:0] a, input logic [1:0] s,
		input logic [2:0] f, input sad_tgt_t t, input logic [32:0] d);
		@(posedge core_clk_in);
		req_valid_in <= 1'b1;
		req_addr_in <= a;
		req_src_in <= s;
		req_flags <= f;
		@(negedge core_clk_in);
		chk(64'(route_code), 64'(t));
		chk(64'(dram_addr_out), 64'(d));
	endtask

	// Cuts a hang short.
	initial begin
		#300000;
		err_count++;
		tally_and_finish();
	end

	// Main sequence.
	initial begin
		int          k;
		logic [1:0]  st;
		logic [63:0] a;
		logic [63:0] sp;
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		rd(SAD_OFS_CTRL, 32'h0000_0000);
		rd(SAD_OFS_LOW_TOP, 32'h0010_0000);
		rd(SAD_OFS_ATTR_HI, 32'h0000_0000);
		rd(8'h80, 32'h0000_0000);
		foreach (rows[i]) begin
			route(64'(rows[i].a), rows[i].s, rows[i].f, rows[i].t,
				rows[i].d);
		end
		// Every segment, every attribute state, first and last byte.
		for (k = 0; k < 13; k++) begin
			st = 2'((k + 1) % 4);
			a = (k < 12) ? 64'(32'h000C_0000 + k * 32'h0000_4000)
				: 64'(32'h000F_0000);
			wr(SAD_OFS_ATTR_LO, (k < 8) ? 32'(st) << (2 * k) : 32'h0);
			wr(SAD_OFS_ATTR_HI, (k < 8) ? 32'h0 : 32'(st) << (2 * (k - 8)));
			route(a, 2'h0, 3'b000, st[0] ? SAD_TGT_DRAM : SAD_TGT_SOUTH,
				st[0] ? 33'(a) : 33'h0);
			a = a + ((k < 12) ? 64'h3FFF : 64'hFFFF);
			route(a, 2'h2, 3'b100, st[1] ? SAD_TGT_DRAM : SAD_TGT_SOUTH,
				st[1] ? 33'(a) : 33'h0);
		end
		// Device-0 register windows, each at both edges.
		for (k = 0; k < 3; k++) begin
			wr(wofs[k], wfld[k]);
			wr(SAD_OFS_CTRL, 32'h1 << wbit[k]);
			route(64'(wbas[k]), 2'h0, 3'b000, SAD_TGT_REGS, 33'h0);
			route(64'(wbas[k] + wsiz[k] - 1), 2'h0, 3'b100, SAD_TGT_REGS,
				33'h0);
			route(64'(wbas[k] + wsiz[k]), 2'h0, 3'b000, SAD_TGT_SOUTH,
				33'h0);
		end
		wr(SAD_OFS_INTERNAL, 32'h0000_0020);
		wr(SAD_OFS_CTRL, 32'h0000_0002);
		route(64'(32'h0008_0000), 2'h0, 3'b000, SAD_TGT_DRAM,
			33'h0_0008_0000);
		// Flat window in each size, codes 2, 1 and 0; code 3 acts as 256 MB.
		for (k = 0; k < 3; k++) begin
			sp = 64'(32'h0400_0000) << k;
			wr(SAD_OFS_FLAT, 32'h0000_0038);
			wr(SAD_OFS_CTRL, 32'h0000_0004 | (32'(2 - k) << 3));
			route(64'(32'hE000_0000) + sp - 1, 2'h0, 3'b000, SAD_TGT_REGS,
				33'h0);
			route(64'(32'hE000_0000) + sp, 2'h0, 3'b000, SAD_TGT_SOUTH,
				33'h0);
		end
		wr(SAD_OFS_CTRL, 32'h0000_001C);
		route(64'(32'hEFFF_FFFF), 2'h0, 3'b000, SAD_TGT_REGS,
			33'h0);
		// Low top at 1 GB; peer writes below it only from the south link.
		wr(SAD_OFS_CTRL, 32'h0000_0000);
		wr(SAD_OFS_LOW_TOP, 32'h4000_0000);
		wr(SAD_OFS_NP_WIN, 32'h0100_0100);
		route(64'(32'h1000_0000), 2'h2, 3'b100, SAD_TGT_PCIE, 33'h0);
		route(64'(32'h1000_0000), 2'h2, 3'b000, SAD_TGT_DRAM,
			33'h0_1000_0000);
		route(64'(32'h1000_0000), 2'h0, 3'b100, SAD_TGT_DRAM,
			33'h0_1000_0000);
		wr(SAD_OFS_NP_WIN, 32'h080F_0800);
		route(64'(32'h8000_0000), 2'h0, 3'b000, SAD_TGT_PCIE, 33'h0);
		route(64'(32'h8100_0000), 2'h0, 3'b000, SAD_TGT_SOUTH, 33'h0);
		wr(SAD_OFS_IO_WIN, 32'h0000_0302);
		route(64'(32'h0000_2000), 2'h0, 3'b010, SAD_TGT_PCIE, 33'h0);
		route(64'(32'h0000_4000), 2'h0, 3'b010, SAD_TGT_SOUTH, 33'h0);
		wr(SAD_OFS_PF_WIN, 32'h0000_0000);
		wr(SAD_OFS_UPF_BASE, 32'h0000_0010);
		wr(SAD_OFS_UPF_LIMIT, 32'h0000_0010);
		route(64'h0000_0010_0000_0000, 2'h1, 3'b000, SAD_TGT_PCIE,
			33'h0);
		route(64'h0000_0011_0000_0000, 2'h1, 3'b000, SAD_TGT_INVALID,
			33'h0);
		// Reclaim and memory above 4 GB, capped at 8 GB.
		wr(SAD_OFS_RCL_BASE, 32'h0000_1000);
		wr(SAD_OFS_RCL_LIMIT, 32'h0000_1003);
		wr(SAD_OFS_UPPER_TOP, 32'h0000_3000);
		wr(SAD_OFS_CTRL, 32'h1 << SAD_CTRL_RECLAIM_EN);
		route(64'h0000_0001_0010_0000, 2'h0, 3'b000, SAD_TGT_DRAM,
			33'h0_4010_0000);
		route(64'h0000_0001_8000_0000, 2'h0, 3'b000, SAD_TGT_DRAM,
			33'h1_8000_0000);
		route(64'h0000_0002_0000_0000, 2'h0, 3'b000, SAD_TGT_INVALID,
			33'h0);
		@(posedge core_clk_in);
		req_valid_in <= 1'b0;
		@(negedge core_clk_in);
		chk(64'(route_code), 64'(SAD_TGT_NONE));
		// Second reset mid-run: attributes and status return to reset.
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		rd(SAD_OFS_ATTR_HI, 32'h0000_0000);
		route(64'(32'h000F_FFFF), 2'h0, 3'b000, SAD_TGT_SOUTH,
			33'h0);
		@(posedge core_clk_in);
		req_valid_in <= 1'b0;
		rd(SAD_OFS_STATUS, 32'h0001_0002);
		tally_and_finish();
	end
endmodule
